// file: pss_pkg.sv
`default_nettype none
package pss_pkg;
    // Bus and bank geometry
    localparam int ADDR_W = 12;
    localparam int CPU_W = 2;
    localparam int BANK_W = 32;
    localparam int SW_N = 16;
    localparam int PRIV_N = 16;
    localparam int SHR_FIRST = 32;
    // Register map
    localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
    localparam logic [ADDR_W-1:0] GRP_BASE = 12'h080;
    localparam logic [ADDR_W-1:0] SET_BASE = 12'h200;
    localparam logic [ADDR_W-1:0] CLR_BASE = 12'h280;
    localparam logic [ADDR_W-1:0] EDGE_BASE = 12'hc00;
    localparam int CTRL_LOCK_BIT = 0;
    localparam int PROT_NS_BIT = 1;
    // Reset values and responses
    localparam logic RST_BIT = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Word-aligned hit inside a bank of n registers
    function automatic logic in_bank(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base,
                                     input int n);
        logic [ADDR_W-1:0] off;
        off = a - base;
        in_bank = (a[1:0] == 2'h0) && (a >= base)
                  && ({22'h0, off[ADDR_W-1:2]} < 32'(n));
    endfunction : in_bank

    // Register index inside a bank
    function automatic logic [9:0] bank_of(input logic [ADDR_W-1:0] a,
                                           input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off = a - base;
        bank_of = off[ADDR_W-1:2];
    endfunction : bank_of

    // Byte strobes widened to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask
endpackage : pss_pkg
`default_nettype wire

// file: pss_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pss_reg_if;
    import pss_pkg::*;
    // Write side, one cycle per completed write
    logic wr_req;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ns;
    logic [CPU_W-1:0] wr_cpu;
    logic wr_ok;
    // Read side, looked up combinationally
    logic [ADDR_W-1:0] rd_addr;
    logic rd_ns;
    logic [CPU_W-1:0] rd_cpu;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus (output wr_req, wr_addr, wr_data, wr_strb, wr_ns, wr_cpu,
                 output rd_addr, rd_ns, rd_cpu,
                 input wr_ok, rd_data, rd_ok);
    modport core (input wr_req, wr_addr, wr_data, wr_strb, wr_ns, wr_cpu,
                  input rd_addr, rd_ns, rd_cpu,
                  output wr_ok, rd_data, rd_ok);
endinterface : pss_reg_if
`default_nettype wire

// file: pss_pend_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pss_pend_cell
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Source and configuration
    input wire logic edge_mode,
    input wire logic line_in,
    // Write-one strobes
    input wire logic set_wr,
    input wire logic clr_wr,
    // Status
    output logic pending,
    output logic latched
);
    logic latch_reg, latch_next, line_reg, line_next, rise, ev;

    // Latch: set events win over a clear in the same cycle
    always_comb
    begin
        line_next = line_in;
        rise = line_in & ~line_reg;
        ev = set_wr | (edge_mode & rise);
        if (ev)
            latch_next = 1'b1;
        else if (clr_wr)
            latch_next = 1'b0;
        else
            latch_next = latch_reg;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latch_reg <= RST_BIT;
            line_reg <= RST_BIT;
        end
        else
        begin
            latch_reg <= latch_next;
            line_reg <= line_next;
        end
    end

    // Level sources stay pending while the line is high
    assign pending = latch_reg | (~edge_mode & line_in);
    assign latched = latch_reg;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_set_level;
        !edge_mode && set_wr;
    endsequence

    property p_set_makes_pending;
        set_wr |=> latch_reg;
    endproperty
    a_set_makes_pending: assert property (p_set_makes_pending)
        else $error("set write did not latch pending");

    property p_set_beats_clear;
        ev && clr_wr |=> latch_reg;
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("clear won over set");

    property p_edge_clear;
        edge_mode && clr_wr && !set_wr && !rise |=> !latch_reg;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("edge clear left pending");

    property p_level_follows;
        !edge_mode && line_in |-> pending;
    endproperty
    a_level_follows: assert property (p_level_follows)
        else $error("asserted level source not pending");

    property p_level_latch_holds;
        s_set_level ##1 (!clr_wr && !edge_mode)[*2] |=> pending;
    endproperty
    a_level_latch_holds: assert property (p_level_latch_holds)
        else $error("latched level pending was lost");

    property p_quiet_keeps;
        !set_wr && !clr_wr && !(edge_mode && rise) |=> $stable(latch_reg);
    endproperty
    a_quiet_keeps: assert property (p_quiet_keeps)
        else $error("latch changed without an event");
endmodule : pss_pend_cell
`default_nettype wire

// file: pss_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module pss_axil_slave
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address, data, response
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic [CPU_W-1:0] aw_cpu,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address and data
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic [CPU_W-1:0] ar_cpu,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Core side
    pss_reg_if.bus rif
);
    logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
    logic arr_reg, arr_next, rv_reg, rv_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next, wd_reg, wd_next;
    logic [3:0] ws_reg, ws_next;
    logic [ADDR_W-1:0] wa_reg, wa_next;
    logic ns_reg, ns_next;
    logic [CPU_W-1:0] cpu_reg, cpu_next;

    // Write completes once both halves are held and no answer waits
    assign rif.wr_req = !awr_reg && !wr_reg && !bv_reg;
    assign rif.wr_addr = wa_reg;
    assign rif.wr_data = wd_reg;
    assign rif.wr_strb = ws_reg;
    assign rif.wr_ns = ns_reg;
    assign rif.wr_cpu = cpu_reg;
    assign rif.rd_addr = araddr;
    assign rif.rd_ns = arprot[PROT_NS_BIT];
    assign rif.rd_cpu = ar_cpu;

    // Channel handshakes
    always_comb
    begin
        awr_next = awr_reg;
        wr_next = wr_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        arr_next = arr_reg;
        rv_next = rv_reg;
        rr_next = rr_reg;
        rd_next = rd_reg;
        wa_next = wa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        ns_next = ns_reg;
        cpu_next = cpu_reg;
        if (awvalid && awr_reg)
        begin
            awr_next = 1'b0;
            wa_next = awaddr;
            ns_next = awprot[PROT_NS_BIT];
            cpu_next = aw_cpu;
        end
        if (wvalid && wr_reg)
        begin
            wr_next = 1'b0;
            wd_next = wdata;
            ws_next = wstrb;
        end
        if (rif.wr_req)
        begin
            awr_next = 1'b1;
            wr_next = 1'b1;
            bv_next = 1'b1;
            br_next = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (bv_reg && bready)
            bv_next = 1'b0;
        if (arvalid && arr_reg)
        begin
            arr_next = 1'b0;
            rv_next = 1'b1;
            rd_next = rif.rd_data;
            rr_next = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (rv_reg && rready)
        begin
            rv_next = 1'b0;
            arr_next = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awr_reg <= 1'b1;
            wr_reg <= 1'b1;
            arr_reg <= 1'b1;
            bv_reg <= RST_BIT;
            rv_reg <= RST_BIT;
            br_reg <= RESP_OKAY;
            rr_reg <= RESP_OKAY;
            rd_reg <= '0;
            wa_reg <= '0;
            wd_reg <= '0;
            ws_reg <= '0;
            ns_reg <= RST_BIT;
            cpu_reg <= '0;
        end
        else
        begin
            awr_reg <= awr_next;
            wr_reg <= wr_next;
            arr_reg <= arr_next;
            bv_reg <= bv_next;
            rv_reg <= rv_next;
            br_reg <= br_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
            wa_reg <= wa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            ns_reg <= ns_next;
            cpu_reg <= cpu_next;
        end
    end

    assign awready = awr_reg;
    assign wready = wr_reg;
    assign bvalid = bv_reg;
    assign bresp = br_reg;
    assign arready = arr_reg;
    assign rvalid = rv_reg;
    assign rresp = rr_reg;
    assign rdata = rd_reg;

    property p_write_answer;
        @(posedge aclk) disable iff (!aresetn)
        rif.wr_req |=> bv_reg && awr_reg && wr_reg;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write answer not raised one cycle after commit");

    property p_read_answer;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arr_reg |=> rv_reg && !arr_reg;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer not raised one cycle after address");
endmodule : pss_axil_slave
`default_nettype wire

// file: pss_pending_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Set read: software/private pending on this CPU, shared anywhere.
// - Edge source: writing 1 sets pending, 0 or repeat does nothing.
// - Level source not pending: writing 1 makes it pending.
// - Level source already latched: another set write changes nothing.
// - Level source pending by line: set write latches, survives deassertion.
// - Set bits of software interrupts ignore writes.
// - Set register n at 0x200 plus 4n, bit m modulo 32.
// - Clear write 1 removes pending; clear read shows pending.
// - Unimplemented interrupt bits read zero and ignore writes.
// - With security, group 0 bits are hidden from non-secure accesses.
// - Lockdown freezes pending bits of lockable group 0 shared interrupts.
// - Clear bits of software interrupts are read-only.
// - Register count is line count plus one, from register zero.
// - Register 0 is banked per processor, covering interrupts 0-31.
// - Banks exist always and are common to both security states.
// - Edge clear: pending drops; no effect when not pending.
// - Level clear drops only the latch; asserted line keeps pending.
// - Level pending latched by write or follows line; edge latches.
module pss_pending_ctrl
    import pss_pkg::*;
#(
    parameter int NUM_CPUS = 2,
    parameter int LINE_COUNT = 1,
    parameter int NUM_SHARED = 24,
    parameter int LOCK_SHARED = 8,
    parameter bit SECURITY = 1'b1
)(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic [CPU_W-1:0] aw_cpu,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic [CPU_W-1:0] ar_cpu,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt sources
    input wire logic [NUM_SHARED-1:0] shared_irq_in,
    input wire logic [NUM_CPUS*PRIV_N-1:0] private_irq_in,
    input wire logic [NUM_CPUS*SW_N-1:0] sw_pending_in,
    // Pending status toward the rest of the distributor
    output logic [NUM_SHARED-1:0] pending_shared,
    output logic [NUM_CPUS*PRIV_N-1:0] pending_private
);
    localparam int NUM_REGS = LINE_COUNT + 1;
    localparam int NUM_IRQ = BANK_W * NUM_REGS;

    pss_reg_if rif ();

    logic [NUM_IRQ-1:0] grp_reg, grp_next, edge_reg, edge_next;
    logic lock_reg, lock_next;
    logic [NUM_SHARED-1:0] shr_out_reg, shr_out_next, shr_pend;
    logic [NUM_CPUS*PRIV_N-1:0] prv_out_reg, prv_out_next, prv_pend;
    logic [NUM_IRQ-1:0] impl_vec, wr_allow, rd_allow, set_hit, clr_hit;
    logic [NUM_IRQ-1:0] view;
    logic [31:0] wfull, rword;
    logic [9:0] wb, rb;
    logic w_set, w_clr, w_grp, w_edge, w_ctrl;
    logic r_pend, r_grp, r_edge, r_ctrl;

    // One bank word out of a per-interrupt vector
    function automatic logic [31:0] pick_word(input logic [NUM_IRQ-1:0] v,
                                              input logic [9:0] b);
        pick_word = '0;
        for (int k = 0; k < NUM_REGS; k++)
        begin
            if (b == 10'(k))
                pick_word = v[k*BANK_W +: BANK_W];
        end
    endfunction : pick_word

    // Bus front end; keeps every bus output on a flip-flop
    pss_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awprot(awprot),
        .aw_cpu(aw_cpu),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arprot(arprot),
        .ar_cpu(ar_cpu),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rif(rif.bus)
    );

    // Address decode, shared by both directions
    always_comb
    begin
        w_set = in_bank(rif.wr_addr, SET_BASE, NUM_REGS);
        w_clr = in_bank(rif.wr_addr, CLR_BASE, NUM_REGS);
        w_grp = in_bank(rif.wr_addr, GRP_BASE, NUM_REGS);
        w_edge = in_bank(rif.wr_addr, EDGE_BASE, NUM_REGS);
        w_ctrl = (rif.wr_addr == CTRL_OFF);
        r_pend = in_bank(rif.rd_addr, SET_BASE, NUM_REGS)
                 || in_bank(rif.rd_addr, CLR_BASE, NUM_REGS);
        r_grp = in_bank(rif.rd_addr, GRP_BASE, NUM_REGS);
        r_edge = in_bank(rif.rd_addr, EDGE_BASE, NUM_REGS);
        r_ctrl = (rif.rd_addr == CTRL_OFF);
        wb = 10'h0;
        if (w_set || w_ctrl)
            wb = bank_of(rif.wr_addr, SET_BASE);
        else if (w_clr)
            wb = bank_of(rif.wr_addr, CLR_BASE);
        else if (w_grp)
            wb = bank_of(rif.wr_addr, GRP_BASE);
        else if (w_edge)
            wb = bank_of(rif.wr_addr, EDGE_BASE);
        if (r_ctrl)
            rb = 10'h0;
        else if (r_grp)
            rb = bank_of(rif.rd_addr, GRP_BASE);
        else if (r_edge)
            rb = bank_of(rif.rd_addr, EDGE_BASE);
        else if (rif.rd_addr >= CLR_BASE)
            rb = bank_of(rif.rd_addr, CLR_BASE);
        else
            rb = bank_of(rif.rd_addr, SET_BASE);
        wfull = rif.wr_data & strb_mask(rif.wr_strb);
    end

    // Which bits exist and which an access may touch
    always_comb
    begin
        for (int i = 0; i < NUM_IRQ; i++)
        begin
            impl_vec[i] = (i < SHR_FIRST) || (i < SHR_FIRST + NUM_SHARED);
            wr_allow[i] = impl_vec[i] && (i >= SW_N)
                && !(SECURITY && rif.wr_ns && !grp_reg[i])
                && !(SECURITY && lock_reg && !grp_reg[i]
                     && i >= SHR_FIRST
                     && i < SHR_FIRST + LOCK_SHARED);
            rd_allow[i] = impl_vec[i]
                && !(SECURITY && rif.rd_ns && !grp_reg[i]);
        end
    end

    // Write-one strobes per interrupt for the writing processor
    always_comb
    begin
        set_hit = '0;
        clr_hit = '0;
        for (int i = 0; i < NUM_IRQ; i++)
        begin
            if (rif.wr_req && wb == 10'(i / BANK_W)
                && wfull[i % BANK_W] && wr_allow[i])
            begin
                set_hit[i] = w_set;
                clr_hit[i] = w_clr;
            end
        end
    end

    // Private cells, one copy per processor
    for (genvar c = 0; c < NUM_CPUS; c++)
    begin : g_cpu
        for (genvar i = 0; i < PRIV_N; i++)
        begin : g_prv
            pss_pend_cell u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .edge_mode(edge_reg[SW_N+i]),
                .line_in(private_irq_in[c*PRIV_N+i]),
                .set_wr(set_hit[SW_N+i] && rif.wr_cpu == CPU_W'(c)),
                .clr_wr(clr_hit[SW_N+i] && rif.wr_cpu == CPU_W'(c)),
                .pending(prv_pend[c*PRIV_N+i]),
                .latched()
            );
        end
    end

    // Shared cells, common to every processor and both security states
    for (genvar i = 0; i < NUM_SHARED; i++)
    begin : g_shr
        pss_pend_cell u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .edge_mode(edge_reg[SHR_FIRST+i]),
            .line_in(shared_irq_in[i]),
            .set_wr(set_hit[SHR_FIRST+i]),
            .clr_wr(clr_hit[SHR_FIRST+i]),
            .pending(shr_pend[i]),
            .latched()
        );
    end

    // Read view for the reading processor
    always_comb
    begin
        view = '0;
        for (int c = 0; c < NUM_CPUS; c++)
        begin
            if (rif.rd_cpu == CPU_W'(c))
            begin
                view[0 +: SW_N] = sw_pending_in[c*SW_N +: SW_N];
                view[SW_N +: PRIV_N] = prv_pend[c*PRIV_N +: PRIV_N];
            end
        end
        view[SHR_FIRST +: NUM_SHARED] = shr_pend;
        rword = 32'h0;
        if (r_pend)
            rword = pick_word(view & rd_allow, rb);
        else if (r_grp && !rif.rd_ns)
            rword = pick_word(grp_reg & impl_vec, rb);
        else if (r_edge)
            rword = pick_word(edge_reg & rd_allow, rb);
        else if (r_ctrl)
            rword[CTRL_LOCK_BIT] = lock_reg;
        rif.rd_data = rword;
        rif.rd_ok = r_pend || r_grp || r_edge || r_ctrl;
        rif.wr_ok = w_set || w_clr || w_grp || w_edge || w_ctrl;
    end

    // Configuration; group and lock only take secure writes
    always_comb
    begin
        grp_next = grp_reg;
        edge_next = edge_reg;
        lock_next = lock_reg;
        for (int i = 0; i < NUM_IRQ; i++)
        begin
            if (rif.wr_req && wb == 10'(i / BANK_W) && impl_vec[i])
            begin
                if (w_grp && !rif.wr_ns)
                    grp_next[i] = wfull[i % BANK_W];
                if (w_edge && wr_allow[i])
                    edge_next[i] = wfull[i % BANK_W];
            end
        end
        // Lock is sticky until reset, so software cannot undo it
        if (rif.wr_req && w_ctrl && !rif.wr_ns && wfull[CTRL_LOCK_BIT])
            lock_next = 1'b1;
        shr_out_next = shr_pend;
        prv_out_next = prv_pend;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            grp_reg <= '0;
            edge_reg <= '0;
            lock_reg <= RST_BIT;
            shr_out_reg <= '0;
            prv_out_reg <= '0;
        end
        else
        begin
            grp_reg <= grp_next;
            edge_reg <= edge_next;
            lock_reg <= lock_next;
            shr_out_reg <= shr_out_next;
            prv_out_reg <= prv_out_next;
        end
    end

    assign pending_shared = shr_out_reg;
    assign pending_private = prv_out_reg;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_unimpl_zero;
        rif.rd_ok && r_pend |-> (rif.rd_data & ~pick_word(impl_vec, rb)) == 0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented pending bit read as one");

    property p_ns_hides_grp0;
        SECURITY && r_pend && rif.rd_ns
            |-> (rif.rd_data & ~pick_word(grp_reg, rb)) == 0;
    endproperty
    a_ns_hides_grp0: assert property (p_ns_hides_grp0)
        else $error("group 0 pending visible to non-secure read");

    property p_sw_never_written;
        rif.wr_req |-> (set_hit[SW_N-1:0] == 0) && (clr_hit[SW_N-1:0] == 0);
    endproperty
    a_sw_never_written: assert property (p_sw_never_written)
        else $error("software interrupt pending bit took a write");

    property p_outputs_follow;
        ##1 1'b1 |-> pending_shared == $past(shr_pend);
    endproperty
    a_outputs_follow: assert property (p_outputs_follow)
        else $error("shared pending output lagged by more than a cycle");
endmodule : pss_pending_ctrl
`default_nettype wire

// file: pss_irq_src.sv
`timescale 1ns/1ps
`default_nettype none
module pss_irq_src
(
    // Clock
    input wire logic aclk,
    // Requested line levels, shared in the low bits
    input wire logic [55:0] req,
    // Lines toward the block
    output logic [23:0] shr,
    output logic [31:0] prv
);
    // Lines change only at clock edges, as the block samples them
    always_ff @(posedge aclk)
    begin
        shr <= req[23:0];
        prv <= req[55:24];
    end
endmodule : pss_irq_src
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pss_pkg::*;
    // Bus signals
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [2:0] awprot = '0, arprot = '0;
    logic [CPU_W-1:0] aw_cpu = '0, ar_cpu = '0;
    logic [31:0] wdata = '0, rdata, rd_v;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rd_r;
    // Sources and status
    logic [55:0] req = '0;
    logic [23:0] shared_irq_in, pending_shared;
    logic [31:0] private_irq_in, pending_private;
    logic [31:0] sw_pending_in = 32'h1;
    int n_errors = 0, tests_run = 0;
    always #5 aclk = ~aclk;
    pss_pending_ctrl i_pss_pending_ctrl (.*);
    pss_irq_src i_pss_irq_src (.aclk(aclk), .req(req),
        .shr(shared_irq_in), .prv(private_irq_in));
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    // A wait that ran out ends the run
    task automatic hang(int n);
        if (n >= 50)
        begin
            n_errors++;
            end_of_test();
        end
    endtask : hang
    // Edge first, so no signal is driven twice in one step
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [2:0] p,
                      logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        awprot <= p;
        // Prot bit 0 means nothing to the block, so it names the writer
        aw_cpu <= {1'b0, p[0]};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        hang(n);
        cmp("bresp", 32'(er), 32'(bresp));
    endtask : wr
    task automatic rd(logic [11:0] a, logic [2:0] p, logic [1:0] c);
        int n;
        @(posedge aclk);
        araddr <= a;
        arprot <= p;
        ar_cpu <= c;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        hang(n);
        rd_v = rdata;
        rd_r = rresp;
    endtask : rd
    // Interrupt 40 is bit 8 of set bank 1, interrupt 41 bit 9
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        wr(SET_BASE + 12'h4, 32'h100, 3'h0, RESP_OKAY);
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("set", 32'h100, rd_v);
        cmp("rresp", 32'(RESP_OKAY), 32'(rd_r));
        rd(CLR_BASE + 12'h4, 3'h0, 2'h0);
        cmp("clr", 32'h100, rd_v);
        rd(SET_BASE + 12'h4, 3'h2, 2'h0);
        cmp("ns", 32'h0, rd_v);
        wr(CLR_BASE + 12'h4, 32'h100, 3'h2, RESP_OKAY);
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("ns clr", 32'h100, rd_v);
        wr(SET_BASE + 12'h4, 32'h100, 3'h0, RESP_OKAY);
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("keep", 32'h100, rd_v);
        wr(CLR_BASE + 12'h4, 32'h100, 3'h0, RESP_OKAY);
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("cleared", 32'h0, rd_v);
        $display("done level write");
        req[8] <= 1'b1;
        wr(CLR_BASE + 12'h4, 32'h100, 3'h0, RESP_OKAY);
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("line", 32'h100, rd_v);
        cmp("out", 32'h1, 32'(pending_shared[8]));
        wr(SET_BASE + 12'h4, 32'h100, 3'h0, RESP_OKAY);
        req[8] <= 1'b0;
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("held", 32'h100, rd_v);
        wr(CLR_BASE + 12'h4, 32'h100, 3'h0, RESP_OKAY);
        $display("done level line");
        wr(EDGE_BASE + 12'h4, 32'h200, 3'h0, RESP_OKAY);
        req[9] <= 1'b1;
        repeat (3) @(posedge aclk);
        req[9] <= 1'b0;
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("edge", 32'h200, rd_v);
        wr(SET_BASE + 12'h4, 32'h200, 3'h0, RESP_OKAY);
        wr(CLR_BASE + 12'h4, 32'h200, 3'h0, RESP_OKAY);
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("edge clr", 32'h0, rd_v);
        $display("done edge");
        req[40] <= 1'b1;
        wr(SET_BASE, 32'hffff, 3'h0, RESP_OKAY);
        wr(CLR_BASE, 32'h1, 3'h0, RESP_OKAY);
        rd(SET_BASE, 3'h0, 2'h0);
        cmp("cpu0", 32'h1, rd_v);
        rd(CLR_BASE, 3'h0, 2'h1);
        cmp("cpu1", 32'h10000, rd_v);
        cmp("prv", 32'h1, 32'(pending_private[16]));
        wr(SET_BASE, 32'h20000, 3'h1, RESP_OKAY);
        rd(SET_BASE, 3'h0, 2'h0);
        cmp("cpu0 bank", 32'h1, rd_v);
        rd(SET_BASE, 3'h0, 2'h1);
        cmp("cpu1 bank", 32'h30000, rd_v);
        $display("done bank0");
        wstrb <= 4'hd;
        wr(SET_BASE + 12'h4, 32'h0100_0100, 3'h0, RESP_OKAY);
        wstrb <= 4'hf;
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("unimpl", 32'h0, rd_v);
        wr(SET_BASE + 12'h8, 32'h1, 3'h0, RESP_SLVERR);
        rd(SET_BASE + 12'h8, 3'h0, 2'h0);
        cmp("rresp bad", 32'(RESP_SLVERR), 32'(rd_r));
        wr(SET_BASE + 12'h4, 32'h1, 3'h0, RESP_OKAY);
        wr(CTRL_OFF, 32'h1, 3'h0, RESP_OKAY);
        wr(CLR_BASE + 12'h4, 32'h1, 3'h0, RESP_OKAY);
        rd(SET_BASE + 12'h4, 3'h0, 2'h0);
        cmp("locked", 32'h1, rd_v);
        $display("done limits");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
